/* File: src/sss_top.sv */
// Purpose: Stop and start source selector with an AXI4-Lite register file.
// Assumes: Drive state and words arrive from logic on the same clock.
// Notes: Ramp and coast actions are carried out by the neighbouring blocks.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module sss_top
    import sss_pkg::*;
#(
    parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Drive state and source words.
    input wire logic drive_running,
    input wire logic [15:0] input_status_word,
    input wire logic [15:0] bidir_io_status_word,
    input wire logic [15:0] adapter_control_word,
    input wire logic [15:0] embedded_bus_control_word,
    // Function outputs.
    output logic ramp_emergency_stop_r,
    output logic start_permission_r,
    output logic coast_stop_r,
    // AXI4-Lite write address channel.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Control cycle divider counter.
    logic [15:0] div_cnt_r;
    // One-cycle pulse that marks each control cycle.
    logic cycle_en_r;
    // Selection codes and control bits held by software.
    logic [31:0] stop_sel_r;
    logic [31:0] start_sel_r;
    logic [31:0] ctrl_r;
    // Sticky flag for a selection write refused while running.
    logic reject_r;
    // Captured write address and data, waiting for each other.
    logic [7:0] aw_addr_r;
    logic aw_got_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_got_r;
    // Sampled source bits from the two selectors.
    wire logic stop_src;
    wire logic start_src;

    // Divider produces one enable pulse per control cycle.
    wire logic div_wrap = (div_cnt_r == 16'(CYCLE_CLKS - 1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            div_cnt_r <= 16'h0000;
            cycle_en_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_wrap ? 16'h0000 : div_cnt_r + 16'h0001;
            cycle_en_r <= div_wrap;
        end
    end

    // Ramp stop selector.
    sss_bit_select u_stop_sel (
        .clock(clock),
        .rst(rst),
        .cycle_en(cycle_en_r),
        .sel_code(stop_sel_r),
        .input_status_word(input_status_word),
        .bidir_io_status_word(bidir_io_status_word),
        .adapter_control_word(adapter_control_word),
        .embedded_bus_control_word(embedded_bus_control_word),
        .src_bit_r(stop_src)
    );

    // Start permission selector.
    sss_bit_select u_start_sel (
        .clock(clock),
        .rst(rst),
        .cycle_en(cycle_en_r),
        .sel_code(start_sel_r),
        .input_status_word(input_status_word),
        .bidir_io_status_word(bidir_io_status_word),
        .adapter_control_word(adapter_control_word),
        .embedded_bus_control_word(embedded_bus_control_word),
        .src_bit_r(start_src)
    );

    // Fieldbus stop requests, each gated by its enable bit. The words are
    // read every clock: the bus decoder already holds them per cycle.
    wire logic adapter_stop = ctrl_r[CTRL_ADAPTER_EN_BIT]
        & ~adapter_control_word[CW_STOP_BIT];
    wire logic embedded_stop = ctrl_r[CTRL_EMBEDDED_EN_BIT]
        & ~embedded_bus_control_word[CW_STOP_BIT];

    // A low source bit means the stop is active.
    wire logic stop_nxt = ~stop_src | adapter_stop | embedded_stop;
    // Permission off while running asks the motor to coast.
    wire logic coast_nxt = ~start_src & drive_running;

    // Function outputs, registered so that the ports come from flops.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ramp_emergency_stop_r <= 1'b0;
            start_permission_r <= 1'b0;
            coast_stop_r <= 1'b0;
        end
        else
        begin
            ramp_emergency_stop_r <= stop_nxt;
            start_permission_r <= start_src;
            coast_stop_r <= coast_nxt;
        end
    end

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Handshakes seen on the channels this cycle.
    wire logic aw_hs = s_axi_awvalid & s_axi_awready;
    wire logic w_hs = s_axi_wvalid & s_axi_wready;
    wire logic b_hs = s_axi_bvalid & s_axi_bready;
    wire logic ar_hs = s_axi_arvalid & s_axi_arready;
    wire logic r_hs = s_axi_rvalid & s_axi_rready;

    // A write is carried out once address and data are both held.
    wire logic wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;

    // Write address decode.
    wire logic wr_stop = wr_do & (aw_addr_r[7:2] == REG_STOP_SEL[7:2]);
    wire logic wr_start = wr_do & (aw_addr_r[7:2] == REG_START_SEL[7:2]);
    wire logic wr_ctrl = wr_do & (aw_addr_r[7:2] == REG_CTRL[7:2]);
    wire logic wr_stat = wr_do & (aw_addr_r[7:2] == REG_STATUS[7:2]);
    wire logic wr_hit = wr_stop | wr_start | wr_ctrl | wr_stat;
    // Selections are locked while the drive runs.
    wire logic wr_locked = (wr_stop | wr_start) & drive_running;
    wire logic [1:0] wr_resp = (wr_hit & ~wr_locked) ? RESP_OKAY
        : RESP_SLVERR;

    // Write channel capture and response.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            // Each channel closes after its own handshake.
            if (aw_hs)
            begin
                aw_addr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Both held: perform the write and post the response.
            if (wr_do)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp;
            end
            // Reopen both channels only once the response is taken.
            if (b_hs)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register storage; a locked write leaves the old selection in force.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stop_sel_r <= STOP_SEL_RESET;
            start_sel_r <= START_SEL_RESET;
            ctrl_r <= CTRL_RESET;
        end
        else
        begin
            if (wr_stop & ~drive_running)
            begin
                stop_sel_r <= merge(stop_sel_r, w_data_r, w_strb_r);
            end
            if (wr_start & ~drive_running)
            begin
                start_sel_r <= merge(start_sel_r, w_data_r, w_strb_r);
            end
            if (wr_ctrl)
            begin
                ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & CTRL_MASK;
            end
        end
    end

    // Reject flag: writing 1 clears it, a new refusal in the same cycle
    // wins so that no refusal goes unseen.
    wire logic reject_clr = wr_stat & w_strb_r[0] & w_data_r[STAT_REJECT_BIT];

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reject_r <= 1'b0;
        end
        else if (wr_locked)
        begin
            reject_r <= 1'b1;
        end
        else if (reject_clr)
        begin
            reject_r <= 1'b0;
        end
    end

    // Status word assembled from the block's own state and the drive state input.
    wire logic [31:0] status_word = {27'h0000000, reject_r, drive_running,
        coast_stop_r, start_permission_r, ramp_emergency_stop_r};

    // Read address decode.
    wire logic rd_stop = (s_axi_araddr[7:2] == REG_STOP_SEL[7:2]);
    wire logic rd_start = (s_axi_araddr[7:2] == REG_START_SEL[7:2]);
    wire logic rd_ctrl = (s_axi_araddr[7:2] == REG_CTRL[7:2]);
    wire logic rd_stat = (s_axi_araddr[7:2] == REG_STATUS[7:2]);
    wire logic rd_hit = rd_stop | rd_start | rd_ctrl | rd_stat;
    wire logic [31:0] rd_data =
        rd_stop ? stop_sel_r :
        rd_start ? start_sel_r :
        rd_ctrl ? ctrl_r :
        rd_stat ? status_word :
        32'h0000_0000;

    // Read channel: data stands from the edge after the address handshake.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r_hs)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: src/sss_pkg.sv */
// Purpose: Constants shared by the stop and start source selector.
// Assumes: One drive control clock at 125 MHz, synchronous reset.
// Notes: Selection codes follow the 32-bit bus equivalent code layout.
package sss_pkg;

    // Clock rate and control cycle; the cycle count derives from both.
    localparam int CLK_FREQ_MHZ = 125;
    localparam int CTRL_CYCLE_NS = 1000;
    localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS * CLK_FREQ_MHZ) / 1000;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] REG_STOP_SEL = 8'h00;
    localparam logic [7:0] REG_START_SEL = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Control register fields.
    localparam int CTRL_ADAPTER_EN_BIT = 0;
    localparam int CTRL_EMBEDDED_EN_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0003;

    // Status register fields.
    localparam int STAT_STOP_BIT = 0;
    localparam int STAT_PERMIT_BIT = 1;
    localparam int STAT_COAST_BIT = 2;
    localparam int STAT_RUNNING_BIT = 3;
    localparam int STAT_REJECT_BIT = 4;

    // Selection code layout: kind, bit number, group and index.
    localparam int CODE_KIND_HI = 31;
    localparam int CODE_KIND_LO = 30;
    localparam int CODE_BIT_HI = 23;
    localparam int CODE_BIT_LO = 16;
    localparam int CODE_WORD_HI = 15;
    localparam int CODE_WORD_LO = 0;
    localparam logic [1:0] KIND_POINTER = 2'h1;
    localparam logic [1:0] KIND_CONST = 2'h2;

    // Status and control words that a pointer may name, by group and index.
    localparam logic [15:0] WORD_INPUT_STATUS = 16'h0201;
    localparam logic [15:0] WORD_BIDIR_STATUS = 16'h0203;
    localparam logic [15:0] WORD_ADAPTER_CW = 16'h0222;
    localparam logic [15:0] WORD_EMBEDDED_CW = 16'h0236;

    // Fixed selection codes of the listed sources.
    localparam logic [31:0] CODE_INPUT_ONE = 32'h4000_0201;
    localparam logic [31:0] CODE_INPUT_TWO = 32'h4001_0201;
    localparam logic [31:0] CODE_INPUT_THREE = 32'h4002_0201;
    localparam logic [31:0] CODE_INPUT_FOUR = 32'h4003_0201;
    localparam logic [31:0] CODE_INPUT_FIVE = 32'h4004_0201;
    localparam logic [31:0] CODE_INPUT_SIX = 32'h4005_0201;
    localparam logic [31:0] CODE_BIDIR_FOUR = 32'h4003_0203;
    localparam logic [31:0] CODE_BIDIR_FIVE = 32'h4004_0203;
    localparam logic [31:0] CODE_BIDIR_SIX = 32'h4005_0203;
    localparam logic [31:0] CODE_CONST_ZERO = 32'h8000_0000;
    localparam logic [31:0] CODE_CONST_ONE = 32'h8000_0001;

    // Reset selections: no stop requested, start permitted.
    localparam logic [31:0] STOP_SEL_RESET = CODE_CONST_ONE;
    localparam logic [31:0] START_SEL_RESET = CODE_CONST_ONE;

    // Control word bit that holds off the ramp stop; low requests stop.
    localparam int CW_STOP_BIT = 0;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/sss_bit_select.sv */
// Purpose: Resolve one selection code to a single sampled source bit.
// Assumes: Status and control words come from logic on the same clock.
// Notes: Unknown codes or words resolve to 0, which is the safe stop side.
`timescale 1ns/1ns
module sss_bit_select
    import sss_pkg::*;
(
    // Clock, reset and control cycle enable.
    input wire logic clock,
    input wire logic rst,
    input wire logic cycle_en,
    // Selection code in force.
    input wire logic [31:0] sel_code,
    // Words that a pointer may address.
    input wire logic [15:0] input_status_word,
    input wire logic [15:0] bidir_io_status_word,
    input wire logic [15:0] adapter_control_word,
    input wire logic [15:0] embedded_bus_control_word,
    // Sampled source bit.
    output logic src_bit_r
);

    // Code fields.
    wire logic [1:0] kind = sel_code[CODE_KIND_HI:CODE_KIND_LO];
    wire logic [7:0] bit_no = sel_code[CODE_BIT_HI:CODE_BIT_LO];
    wire logic [15:0] word_id = sel_code[CODE_WORD_HI:CODE_WORD_LO];

    // Pick the addressed word; an unknown word reads as all zero.
    wire logic [15:0] word =
        (word_id == WORD_INPUT_STATUS) ? input_status_word :
        (word_id == WORD_BIDIR_STATUS) ? bidir_io_status_word :
        (word_id == WORD_ADAPTER_CW) ? adapter_control_word :
        (word_id == WORD_EMBEDDED_CW) ? embedded_bus_control_word :
        16'h0000;

    // Bits above 15 do not exist in a status word and read as zero.
    wire logic in_range = (bit_no[7:4] == 4'h0);
    wire logic ptr_bit = in_range & word[bit_no[3:0]];

    // Constant kind takes its value from the lowest code bit.
    wire logic src_nxt =
        (kind == KIND_POINTER) ? ptr_bit :
        (kind == KIND_CONST) ? sel_code[0] :
        1'b0;

    // Sample once per control cycle, no further filtering.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            src_bit_r <= 1'b1;
        end
        else if (cycle_en)
        begin
            src_bit_r <= src_nxt;
        end
    end

endmodule

/* File: bench/sss_monitor.sv */
// Purpose: Port checks for the stop and start source selector.
// Assumes: One clock, reset synchronous and active high.
// Notes: Bound to the selector top; watches design inputs and outputs.
`timescale 1ns/1ns
module sss_monitor
    import sss_pkg::*;
(
    // Clock, reset and drive state.
    input wire logic clock,
    input wire logic rst,
    input wire logic drive_running,
    // Function outputs.
    input wire logic start_permission_r,
    input wire logic coast_stop_r,
    // Write side of the register bus.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read side of the register bus.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // All checks share the one clock and stand down in reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Both write halves taken together: the write is done one edge later,
    // so the response is first seen two edges after the handshake.
    wr_resp_a: assert property ((s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready) |=> ##1 s_axi_bvalid)
        else $error("write response late");
    // A taken read address gives read data on the next edge.
    rd_resp_a: assert property ((s_axi_arvalid && s_axi_arready)
        |=> s_axi_rvalid) else $error("read data late");
    // A response waits unchanged for the master.
    b_hold_a: assert property ((s_axi_bvalid && !s_axi_bready)
        |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped");
    r_hold_a: assert property ((s_axi_rvalid && !s_axi_rready)
        |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data dropped");
    // The write channels reopen as the response is taken.
    b_done_a: assert property ((s_axi_bvalid && s_axi_bready)
        |=> (!s_axi_bvalid && s_axi_awready && s_axi_wready))
        else $error("write channel not reopened");
    // A selector write while running is refused; the lock is judged at
    // the write edge, one after the handshake, and answered after that.
    sel_lock_a: assert property ((s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready && drive_running &&
        (s_axi_awaddr == REG_STOP_SEL || s_axi_awaddr == REG_START_SEL))
        ##1 drive_running |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
        else $error("lock missed");
    // Coasting only ever comes with permission withdrawn.
    coast_permit_a: assert property (coast_stop_r |->
        !start_permission_r) else $error("coast while permitted");
    // A drive that was not running cannot coast.
    coast_idle_a: assert property (!$past(drive_running) |->
        !coast_stop_r) else $error("coast while idle");
endmodule

bind sss_top sss_monitor mon (
    .clock(clock), .rst(rst), .drive_running(drive_running),
    .start_permission_r(start_permission_r),
    .coast_stop_r(coast_stop_r), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: bench/sss_field_model.sv */
// Purpose: Far side model: input pins and fieldbus control words.
// Assumes: Words refresh once a clock, like the pin status update.
// Notes: Idle level is all ones, so nothing asks for a stop.
`timescale 1ns/1ns
module sss_field_model
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Levels that the bench asks for.
    input wire logic [15:0] pin_req,
    input wire logic [15:0] bidir_req,
    input wire logic [15:0] adapter_req,
    input wire logic [15:0] embedded_req,
    // Words seen by the selector.
    output logic [15:0] in_word_r,
    output logic [15:0] bidir_word_r,
    output logic [15:0] adapter_word_r,
    output logic [15:0] embedded_word_r
);
    // Bit n-1 is input n, bits 3 to 5 are bidir ios four to six.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            in_word_r <= 16'hffff;
            bidir_word_r <= 16'hffff;
            adapter_word_r <= 16'hffff;
            embedded_word_r <= 16'hffff;
        end
        else
        begin
            in_word_r <= pin_req;
            bidir_word_r <= bidir_req;
            adapter_word_r <= adapter_req;
            embedded_word_r <= embedded_req;
        end
    end
endmodule

/* File: bench/test_stop_start_source_select.sv */
// Purpose: Self-checking bench for the stop and start source selector.
// Assumes: Short control cycle so the run stays brief.
// Notes: Waits for outputs cover three control cycles plus pipeline.
`timescale 1ns/1ns
module test_stop_start_source_select;
    import sss_pkg::*;
    localparam int CYC = 4;
    // Fixed bus codes of inputs one to six and bidir ios four to six.
    localparam logic [31:0] SRC [9] = '{32'h4000_0201, 32'h4001_0201,
        32'h4002_0201, 32'h4003_0201, 32'h4004_0201, 32'h4005_0201,
        32'h4003_0203, 32'h4004_0203, 32'h4005_0203};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic drive_running = 1'b0;
    logic [15:0] pin_req = 16'hffff;
    logic [15:0] bidir_req = 16'hffff;
    logic [15:0] adapter_req = 16'hffff;
    logic [15:0] embedded_req = 16'hffff;
    logic [15:0] in_w, bi_w, ad_w, em_w;
    logic stop_o, permit_o, coast_o;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int samples_checked = 0;

    sss_field_model field (.clock(clock), .rst(rst), .pin_req(pin_req),
        .bidir_req(bidir_req), .adapter_req(adapter_req),
        .embedded_req(embedded_req), .in_word_r(in_w),
        .bidir_word_r(bi_w), .adapter_word_r(ad_w),
        .embedded_word_r(em_w));
    sss_top #(.CYCLE_CLKS(CYC)) dut (.clock(clock), .rst(rst),
        .drive_running(drive_running), .input_status_word(in_w),
        .bidir_io_status_word(bi_w), .adapter_control_word(ad_w),
        .embedded_bus_control_word(em_w), .ramp_emergency_stop_r(stop_o),
        .start_permission_r(permit_o), .coast_stop_r(coast_o),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Free-running clock at 125 MHz.
    initial
    begin
        forever #4 clock = ~clock;
    end

    // One comparison; a mismatch is printed and counted at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Write one word; the response is awaited before bready rises.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] exp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clock);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge clock);
        bready <= 1'b0;
        check(32'(bresp), 32'(exp), "write response");
    endtask

    // Read one word and compare data and response.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic [1:0] exp_resp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clock);
        rready <= 1'b1;
        @(posedge clock);
        rready <= 1'b0;
        check(rdata, exp, "read data");
        check(32'(rresp), 32'(exp_resp), "read response");
    endtask

    // Let three control cycles and three clocks pass, then compare the three outputs.
    task automatic outs(input logic s, input logic p, input logic c);
        repeat (3 * CYC + 3) @(posedge clock);
        check(32'(stop_o), 32'(s), "ramp stop");
        check(32'(permit_o), 32'(p), "start permission");
        check(32'(coast_o), 32'(c), "coast stop");
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Cut a hang short well beyond the expected run length.
    initial
    begin
        #400000;
        fails++;
        complete_run();
    end

    // Main sequence of scenarios.
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(REG_STOP_SEL, 32'h8000_0001, RESP_OKAY);
        rd(REG_CTRL, 32'h0000_0003, RESP_OKAY);
        // A write without the low byte lane leaves the enables alone.
        wstrb <= 4'he;
        wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        wstrb <= 4'hf;
        rd(REG_CTRL, 32'h0000_0003, RESP_OKAY);
        outs(1'b0, 1'b1, 1'b0);
        $display("reset test done");
        // Each input pulled low alone raises the stop.
        for (int i = 0; i < 9; i++)
        begin
            wr(REG_STOP_SEL, SRC[i], RESP_OKAY);
            rd(REG_STOP_SEL, SRC[i], RESP_OKAY);
            if (i < 6)
                pin_req <= ~(16'h0001 << i);
            else
                bidir_req <= ~(16'h0001 << (i - 3));
            outs(1'b1, 1'b1, 1'b0);
            pin_req <= 16'hffff;
            bidir_req <= 16'hffff;
            outs(1'b0, 1'b1, 1'b0);
        end
        $display("source map test done");
        wr(REG_STOP_SEL, 32'h8000_0000, RESP_OKAY);
        outs(1'b1, 1'b1, 1'b0);
        wr(REG_STOP_SEL, 32'h4003_0222, RESP_OKAY);
        outs(1'b0, 1'b1, 1'b0);
        adapter_req <= 16'hfff7;
        outs(1'b1, 1'b1, 1'b0);
        adapter_req <= 16'hffff;
        outs(1'b0, 1'b1, 1'b0);
        // A pointer beyond bit 15 names no bit and falls to the stop side.
        wr(REG_STOP_SEL, 32'h4010_0201, RESP_OKAY);
        outs(1'b1, 1'b1, 1'b0);
        wr(REG_STOP_SEL, 32'h8000_0001, RESP_OKAY);
        adapter_req <= 16'hfffe;
        outs(1'b1, 1'b1, 1'b0);
        adapter_req <= 16'hffff;
        embedded_req <= 16'hfffe;
        outs(1'b1, 1'b1, 1'b0);
        wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        outs(1'b0, 1'b1, 1'b0);
        embedded_req <= 16'hffff;
        wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
        $display("bus stop test done");
        wr(REG_START_SEL, 32'h4002_0201, RESP_OKAY);
        pin_req <= 16'hfffb;
        outs(1'b0, 1'b0, 1'b0);
        drive_running <= 1'b1;
        outs(1'b0, 1'b0, 1'b1);
        pin_req <= 16'hffff;
        outs(1'b0, 1'b1, 1'b0);
        $display("start permission test done");
        wr(REG_STOP_SEL, 32'h8000_0000, RESP_SLVERR);
        wr(REG_START_SEL, 32'h8000_0000, RESP_SLVERR);
        rd(REG_STOP_SEL, 32'h8000_0001, RESP_OKAY);
        outs(1'b0, 1'b1, 1'b0);
        rd(REG_STATUS, 32'h0000_001a, RESP_OKAY);
        wr(REG_STATUS, 32'h0000_0010, RESP_OKAY);
        rd(REG_STATUS, 32'h0000_000a, RESP_OKAY);
        drive_running <= 1'b0;
        wr(REG_STOP_SEL, 32'h8000_0000, RESP_OKAY);
        outs(1'b1, 1'b1, 1'b0);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h0, RESP_SLVERR);
        $display("lock and map test done");
        complete_run();
    end
endmodule
